// [bench/test_rdsl_regs.sv]
// Self-checking bench for the radio debug, sync and length registers.
// Assumes the design answers single AHB-Lite word transfers, reads waiting.
`timescale 1ns/1ns
`include "rdsl_map.svh"
module test_rdsl_regs;
    import rdsl_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b1;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic hreadyout_o, hresp_o, debug_pin_a_o, debug_pin_b_o, debug_pin_c_o;
    logic port_drive_boost_o, pkt_end_o, pkt_error_o;
    logic [31:0] hrdata_o;
    logic [63:0] radio_signals_i = 64'h8000_0000_0000_0001;
    logic pkt_start_i = 1'b0;
    logic pkt_byte_valid_i = 1'b0;
    logic [7:0] pkt_byte_i = 8'h0;
    logic [15:0] sync_word_o;
    logic [7:0] pkt_length_o;
    rdsl_len_mode_t length_mode_o;
    int failures = 0;
    int total_checks = 0;
    int ends = 0;
    int errs = 0;
    logic [31:0] rd;
    logic [15:0] idx [8] = '{16'hDF00, 16'hDF01, 16'hDF02, 16'hDF2F,
        16'hDF30, 16'hDF31, 16'hDF40, 16'hDF10};
    logic [7:0] rst [8] = '{8'hD3, 8'h91, 8'hFF, 8'h00, 8'h00, 8'h00,
        8'h01, 8'h00};
    logic [7:0] msk [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h7F,
        8'h03, 8'h00};
    logic [5:0] sels [3] = '{6'h00, 6'h05, 6'h3F};

    rdsl_regs uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
        .hrdata_o(hrdata_o), .hresp_o(hresp_o),
        .radio_signals_i(radio_signals_i), .pkt_start_i(pkt_start_i),
        .pkt_byte_valid_i(pkt_byte_valid_i), .pkt_byte_i(pkt_byte_i),
        .debug_pin_a_o(debug_pin_a_o), .debug_pin_b_o(debug_pin_b_o),
        .debug_pin_c_o(debug_pin_c_o),
        .port_drive_boost_o(port_drive_boost_o),
        .sync_word_o(sync_word_o), .length_mode_o(length_mode_o),
        .pkt_end_o(pkt_end_o), .pkt_error_o(pkt_error_o),
        .pkt_length_o(pkt_length_o));

    // A 40 ns clock for the 25 MHz core.
    always #20 core_clk_i = ~core_clk_i;

    // Pulses last one cycle, so they are counted at every edge.
    always @(posedge core_clk_i) begin
        ends += (pkt_end_o === 1'b1);
        errs += (pkt_error_o === 1'b1);
    end

    // Prints the counts and the verdict, then stops the run.
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Waits for hready high at an edge; a bounded wait guards a hang.
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("BAD %0t bus hang", $time);
            give_verdict();
        end
    endtask

    // One single word transfer; entered just after a rising edge.
    task bus(input logic wr, input logic [15:0] i, input logic [31:0] wd);
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        haddr_i <= {14'h0, i, 2'h0};
        wait_ready();
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_ready();
        rd = hrdata_o;
    endtask

    // One start or byte per edge; only the last call of a run releases,
    // so no strobe is assigned twice in one time step.
    task pkt(input logic st, input logic [7:0] b, input logic more);
        pkt_start_i <= st;
        pkt_byte_valid_i <= ~st;
        pkt_byte_i <= b;
        @(posedge core_clk_i);
        if (!more) begin
            pkt_start_i <= 1'b0;
            pkt_byte_valid_i <= 1'b0;
        end
    endtask

    initial begin
        repeat (8) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        check({16'h0, sync_word_o}, 32'hD391);
        check({31'h0, port_drive_boost_o}, 32'h0);
        // Reset values, then all ones to see which bits are kept.
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, idx[k], 32'h0);
            check(rd, {24'h0, rst[k]});
            bus(1'b1, idx[k], 32'hFFFF_FFFF);
            bus(1'b0, idx[k], 32'h0);
            check(rd, {24'h0, msk[k]});
        end
        repeat (2) @(posedge core_clk_i);
        check({16'h0, sync_word_o}, 32'hFFFF);
        check({31'h0, port_drive_boost_o}, 32'h1);
        // Every pin, with low, mid and top selects in both polarities.
        for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < 6; s++) begin
                bus(1'b1, idx[p+3], {25'h0, s[0], sels[s/2]});
                repeat (2) @(posedge core_clk_i);
                rd[2:0] = {debug_pin_a_o, debug_pin_b_o, debug_pin_c_o};
                check({31'h0, rd[p]},
                    {31'h0, radio_signals_i[sels[s/2]] ^ s[0]});
            end
        end
        check({31'h0, port_drive_boost_o}, 32'h0);
        // Fixed length two: no end after one byte, one end after two.
        bus(1'b1, `RDSL_IDX_LEN_MODE, 32'h0);
        bus(1'b1, `RDSL_IDX_PKT_LEN, 32'h2);
        check({30'h0, length_mode_o}, 32'h0);
        pkt(1'b1, 8'h0, 1'b1);
        pkt(1'b0, 8'h7, 1'b0);
        repeat (2) @(posedge core_clk_i);
        check(ends, 0);
        pkt(1'b0, 8'h9, 1'b0);
        repeat (2) @(posedge core_clk_i);
        check(ends, 1);
        check({24'h0, pkt_length_o}, 32'h2);
        // Variable, limit three: four is refused, three is accepted.
        bus(1'b1, `RDSL_IDX_LEN_MODE, 32'h1);
        bus(1'b1, `RDSL_IDX_PKT_LEN, 32'h3);
        check({30'h0, length_mode_o}, 32'h1);
        pkt(1'b1, 8'h0, 1'b1);
        pkt(1'b0, 8'h4, 1'b0);
        repeat (2) @(posedge core_clk_i);
        check(errs, 1);
        // The status keeps the refused length and a sticky error flag.
        bus(1'b0, `RDSL_IDX_LEN_STATUS, 32'h0);
        check(rd, 32'h0000_0104);
        check({31'h0, hresp_o}, 32'h0);
        bus(1'b1, `RDSL_IDX_LEN_STATUS, 32'h0000_0100);
        bus(1'b0, `RDSL_IDX_LEN_STATUS, 32'h0);
        check(rd, 32'h0000_0004);
        pkt(1'b1, 8'h0, 1'b1);
        for (int b = 0; b < 4; b++) begin
            pkt(1'b0, 8'h3, b < 3);
        end
        repeat (2) @(posedge core_clk_i);
        check(ends, 2);
        check(errs, 1);
        check({24'h0, pkt_length_o}, 32'h3);
        give_verdict();
    end
endmodule

// [logic/rdsl_debug_pin.sv]
// One debug output pin: picks an internal radio signal and sets polarity.
// Assumes the signal bus is synchronous to the core clock.
`timescale 1ns/1ns
module rdsl_debug_pin #(
    parameter int SEL_W = 6
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Configuration.
    input wire logic [SEL_W-1:0] select_i,
    input wire logic invert_i,
    input wire logic [(1<<SEL_W)-1:0] signals_i,
    // Pin.
    output logic pin_o
);
    import rdsl_pkg::*;

    // Select codes wider than eight bits would blow up the mux for nothing.
    initial begin
        if (SEL_W < 1 || SEL_W > 8) begin
            $error("rdsl_debug_pin: SEL_W out of range");
        end
    end

    // Registered so the pin never glitches while the select changes.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_o <= 1'b0;
        end else begin
            pin_o <= signals_i[select_i] ^ invert_i;
        end
    end

endmodule

// [logic/rdsl_length_check.sv]
// Tracks one received packet and flags its end or an over-long length.
// Assumes the packet source pulses start once, then gives bytes in order.
`timescale 1ns/1ns
module rdsl_length_check #(
    parameter int LEN_W = 8
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Configuration.
    input wire rdsl_pkg::rdsl_len_mode_t mode_i,
    input wire logic [LEN_W-1:0] limit_i,
    // Packet byte stream.
    input wire logic start_i,
    input wire logic byte_valid_i,
    input wire logic [LEN_W-1:0] byte_i,
    // Results.
    output logic busy_o,
    output logic end_o,
    output logic error_o,
    output logic [LEN_W-1:0] length_o
);
    import rdsl_pkg::*;

    rdsl_frame_state_t state_reg;
    logic [LEN_W-1:0] remain_reg;

    // The length field is one byte on the air, so wider makes no sense.
    initial begin
        if (LEN_W < 1 || LEN_W > 8) begin
            $error("rdsl_length_check: LEN_W out of range");
        end
    end

    assign busy_o = (state_reg != RDSL_FR_IDLE);

    // Framing walk; a new start always restarts the walk.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= RDSL_FR_IDLE;
            remain_reg <= '0;
            end_o <= 1'b0;
            error_o <= 1'b0;
            length_o <= '0;
        end else begin
            end_o <= 1'b0;
            error_o <= 1'b0;
            if (start_i) begin
                if (mode_i == RDSL_LEN_VARIABLE) begin
                    state_reg <= RDSL_FR_LEN;
                end else if (limit_i == '0) begin
                    state_reg <= RDSL_FR_IDLE;
                    end_o <= 1'b1;
                    length_o <= '0;
                end else begin
                    state_reg <= RDSL_FR_BODY;
                    remain_reg <= limit_i;
                    length_o <= limit_i;
                end
            end else begin
                case (state_reg)
                    RDSL_FR_IDLE: begin
                        state_reg <= RDSL_FR_IDLE;
                    end
                    RDSL_FR_LEN: begin
                        if (byte_valid_i) begin
                            length_o <= byte_i;
                            if (byte_i > limit_i) begin
                                error_o <= 1'b1;
                                state_reg <= RDSL_FR_IDLE;
                            end else if (byte_i == '0) begin
                                end_o <= 1'b1;
                                state_reg <= RDSL_FR_IDLE;
                            end else begin
                                remain_reg <= byte_i;
                                state_reg <= RDSL_FR_BODY;
                            end
                        end
                    end
                    RDSL_FR_BODY: begin
                        if (byte_valid_i) begin
                            remain_reg <= remain_reg - 1'b1;
                            if (remain_reg == 1) begin
                                end_o <= 1'b1;
                                state_reg <= RDSL_FR_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_reg <= RDSL_FR_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// [logic/rdsl_map.svh]
// Register map constants for the radio debug, sync and length registers.
// Assumes AHB-Lite word access; byte address is four times the index.
`ifndef RDSL_MAP_SVH
`define RDSL_MAP_SVH

// Register indices; the byte address is the index shifted left by two.
`define RDSL_IDX_SYNC_HIGH 16'hDF00
`define RDSL_IDX_SYNC_LOW 16'hDF01
`define RDSL_IDX_PKT_LEN 16'hDF02
`define RDSL_IDX_PIN_C 16'hDF2F
`define RDSL_IDX_PIN_B 16'hDF30
`define RDSL_IDX_PIN_A 16'hDF31
`define RDSL_IDX_LEN_MODE 16'hDF40
`define RDSL_IDX_LEN_STATUS 16'hDF41

// Reset values.
`define RDSL_RST_SYNC_HIGH 8'hD3
`define RDSL_RST_SYNC_LOW 8'h91
`define RDSL_RST_PKT_LEN 8'hFF
`define RDSL_RST_PIN_CFG 8'h00
`define RDSL_RST_LEN_MODE 2'h1

// Field positions inside the debug pin configuration registers.
`define RDSL_SEL_MSB 5
`define RDSL_INV_BIT 6
`define RDSL_BOOST_BIT 7

// Field positions inside the length status register.
`define RDSL_STAT_LEN_MSB 7
`define RDSL_STAT_ERR_BIT 8
`define RDSL_STAT_BUSY_BIT 9

`endif

// [logic/rdsl_pkg.sv]
// Types shared by the radio debug, sync and length register block.
// Assumes nothing of its surroundings.
package rdsl_pkg;

    // Framing choice held in the length mode register.
    typedef enum logic [1:0] {
        RDSL_LEN_FIXED = 2'h0,
        RDSL_LEN_VARIABLE = 2'h1,
        RDSL_LEN_RSVD2 = 2'h2,
        RDSL_LEN_RSVD3 = 2'h3
    } rdsl_len_mode_t;

    // Packet length tracker states, one-hot.
    typedef enum logic [2:0] {
        RDSL_FR_IDLE = 3'b001,
        RDSL_FR_LEN = 3'b010,
        RDSL_FR_BODY = 3'b100
    } rdsl_frame_state_t;

endpackage

// [logic/rdsl_regs.sv]
// Radio debug pin, sync word and packet length registers on AHB-Lite.
// Assumes a single AHB-Lite master, word transfers only, one clock.
`timescale 1ns/1ns
`include "rdsl_map.svh"

module rdsl_regs #(
    parameter int SEL_W = 6,
    parameter int LEN_W = 8
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic reset_i,
    // AHB-Lite slave.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic [31:0] hrdata_o,
    output logic hresp_o,
    // Radio side.
    input wire logic [(1<<SEL_W)-1:0] radio_signals_i,
    input wire logic pkt_start_i,
    input wire logic pkt_byte_valid_i,
    input wire logic [LEN_W-1:0] pkt_byte_i,
    // Debug pins and port control.
    output logic debug_pin_a_o,
    output logic debug_pin_b_o,
    output logic debug_pin_c_o,
    output logic port_drive_boost_o,
    // Framing configuration and results.
    output logic [15:0] sync_word_o,
    output rdsl_pkg::rdsl_len_mode_t length_mode_o,
    output logic pkt_end_o,
    output logic pkt_error_o,
    output logic [LEN_W-1:0] pkt_length_o
);
    import rdsl_pkg::*;

    // Register contents; unused bits are simply not stored.
    logic [SEL_W:0] pin_a_cfg_reg;
    logic [SEL_W+1:0] pin_b_cfg_reg;
    logic [SEL_W:0] pin_c_cfg_reg;
    logic [7:0] sync_high_reg;
    logic [7:0] sync_low_reg;
    logic [LEN_W-1:0] pkt_len_reg;
    rdsl_len_mode_t len_mode_reg;
    logic len_error_reg;
    logic len_error_next;

    // Bus data phase state.
    logic addr_accept;
    logic addr_ok;
    logic dp_write_reg;
    logic dp_read_reg;
    logic [15:0] dp_idx_reg;
    logic dp_ok_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rdata_next;
    logic wr_en;

    // Length tracker results.
    logic len_busy;
    logic len_end;
    logic len_error;

    // The register layout fixes the select at six bits and length at eight.
    initial begin
        if (SEL_W != 6 || LEN_W != 8) begin
            $error("rdsl_regs: SEL_W must be 6 and LEN_W must be 8");
        end
    end

    // Address phase decode; the index sits in bits 17:2, nothing aliases.
    assign addr_accept = hsel_i && htrans_i[1] && hready_i;
    assign addr_ok = (haddr_i[31:18] == 14'h0000) && (haddr_i[1:0] == 2'h0);

    // Capture of the address phase for use in the data phase.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            dp_write_reg <= 1'b0;
            dp_read_reg <= 1'b0;
            dp_idx_reg <= 16'h0000;
            dp_ok_reg <= 1'b0;
        end else begin
            dp_write_reg <= addr_accept && hwrite_i;
            if (addr_accept) begin
                dp_read_reg <= !hwrite_i;
                dp_idx_reg <= haddr_i[17:2];
                dp_ok_reg <= addr_ok;
            end else begin
                dp_read_reg <= 1'b0;
            end
        end
    end

    // Reads take one wait state so hrdata comes from a flip-flop and any
    // write just committed ahead of the read is already visible.
    assign hreadyout_o = !dp_read_reg;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_reg;
    assign wr_en = dp_write_reg && dp_ok_reg;

    // Read multiplexer; unused and unmapped bits read zero.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (dp_ok_reg) begin
            case (dp_idx_reg)
                `RDSL_IDX_PIN_A: rdata_next[SEL_W:0] = pin_a_cfg_reg;
                `RDSL_IDX_PIN_B: rdata_next[SEL_W+1:0] = pin_b_cfg_reg;
                `RDSL_IDX_PIN_C: rdata_next[SEL_W:0] = pin_c_cfg_reg;
                `RDSL_IDX_SYNC_HIGH: rdata_next[7:0] = sync_high_reg;
                `RDSL_IDX_SYNC_LOW: rdata_next[7:0] = sync_low_reg;
                `RDSL_IDX_PKT_LEN: rdata_next[LEN_W-1:0] = pkt_len_reg;
                `RDSL_IDX_LEN_MODE: rdata_next[1:0] = len_mode_reg;
                `RDSL_IDX_LEN_STATUS: begin
                    rdata_next[`RDSL_STAT_LEN_MSB:0] = pkt_length_o;
                    rdata_next[`RDSL_STAT_ERR_BIT] = len_error_reg;
                    rdata_next[`RDSL_STAT_BUSY_BIT] = len_busy;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data register, loaded in the wait state of a read.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (dp_read_reg) begin
            hrdata_reg <= rdata_next;
        end
    end

    // Debug pin configuration registers; bit 7 exists only on pin B.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_a_cfg_reg <= (SEL_W+1)'(`RDSL_RST_PIN_CFG);
            pin_b_cfg_reg <= `RDSL_RST_PIN_CFG;
            pin_c_cfg_reg <= (SEL_W+1)'(`RDSL_RST_PIN_CFG);
        end else if (wr_en) begin
            case (dp_idx_reg)
                `RDSL_IDX_PIN_A: pin_a_cfg_reg <= hwdata_i[SEL_W:0];
                `RDSL_IDX_PIN_B: pin_b_cfg_reg <= hwdata_i[SEL_W+1:0];
                `RDSL_IDX_PIN_C: pin_c_cfg_reg <= hwdata_i[SEL_W:0];
                default: pin_a_cfg_reg <= pin_a_cfg_reg;
            endcase
        end
    end

    // Sync word bytes.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sync_high_reg <= `RDSL_RST_SYNC_HIGH;
            sync_low_reg <= `RDSL_RST_SYNC_LOW;
        end else if (wr_en) begin
            if (dp_idx_reg == `RDSL_IDX_SYNC_HIGH) begin
                sync_high_reg <= hwdata_i[7:0];
            end
            if (dp_idx_reg == `RDSL_IDX_SYNC_LOW) begin
                sync_low_reg <= hwdata_i[7:0];
            end
        end
    end

    // Packet length limit and framing mode; reserved codes are stored.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pkt_len_reg <= `RDSL_RST_PKT_LEN;
            len_mode_reg <= rdsl_len_mode_t'(`RDSL_RST_LEN_MODE);
        end else if (wr_en) begin
            if (dp_idx_reg == `RDSL_IDX_PKT_LEN) begin
                pkt_len_reg <= hwdata_i[LEN_W-1:0];
            end
            if (dp_idx_reg == `RDSL_IDX_LEN_MODE) begin
                len_mode_reg <= rdsl_len_mode_t'(hwdata_i[1:0]);
            end
        end
    end

    // Sticky over-length flag, cleared by writing one; a new error in the
    // same cycle as the clear wins so no event is lost.
    always_comb begin
        len_error_next = len_error_reg;
        if (wr_en && dp_idx_reg == `RDSL_IDX_LEN_STATUS &&
            hwdata_i[`RDSL_STAT_ERR_BIT]) begin
            len_error_next = 1'b0;
        end
        if (len_error) begin
            len_error_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            len_error_reg <= 1'b0;
        end else begin
            len_error_reg <= len_error_next;
        end
    end

    // Configuration outputs straight from the registers; packet end and error from the tracker.
    assign sync_word_o = {sync_high_reg, sync_low_reg};
    assign length_mode_o = len_mode_reg;
    assign port_drive_boost_o = pin_b_cfg_reg[`RDSL_BOOST_BIT];
    assign pkt_end_o = len_end;
    assign pkt_error_o = len_error;

    // Three routed debug pins.
    rdsl_debug_pin #(.SEL_W(SEL_W)) u_pin_a (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .select_i(pin_a_cfg_reg[`RDSL_SEL_MSB:0]),
        .invert_i(pin_a_cfg_reg[`RDSL_INV_BIT]),
        .signals_i(radio_signals_i),
        .pin_o(debug_pin_a_o)
    );

    rdsl_debug_pin #(.SEL_W(SEL_W)) u_pin_b (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .select_i(pin_b_cfg_reg[`RDSL_SEL_MSB:0]),
        .invert_i(pin_b_cfg_reg[`RDSL_INV_BIT]),
        .signals_i(radio_signals_i),
        .pin_o(debug_pin_b_o)
    );

    rdsl_debug_pin #(.SEL_W(SEL_W)) u_pin_c (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .select_i(pin_c_cfg_reg[`RDSL_SEL_MSB:0]),
        .invert_i(pin_c_cfg_reg[`RDSL_INV_BIT]),
        .signals_i(radio_signals_i),
        .pin_o(debug_pin_c_o)
    );

    // Packet length tracker driven by the live limit and mode.
    rdsl_length_check #(.LEN_W(LEN_W)) u_len (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .mode_i(len_mode_reg),
        .limit_i(pkt_len_reg),
        .start_i(pkt_start_i),
        .byte_valid_i(pkt_byte_valid_i),
        .byte_i(pkt_byte_i),
        .busy_o(len_busy),
        .end_o(len_end),
        .error_o(len_error),
        .length_o(pkt_length_o)
    );

    // Expected pin levels and write strobes, used only by the checks below.
    logic pin_a_expect;
    logic pin_c_expect;
    logic pin_b_write;
    logic mode_write;
    assign pin_a_expect = radio_signals_i[pin_a_cfg_reg[`RDSL_SEL_MSB:0]] ^
                          pin_a_cfg_reg[`RDSL_INV_BIT];
    assign pin_c_expect = radio_signals_i[pin_c_cfg_reg[`RDSL_SEL_MSB:0]] ^
                          pin_c_cfg_reg[`RDSL_INV_BIT];
    assign pin_b_write = wr_en && dp_idx_reg == `RDSL_IDX_PIN_B;
    assign mode_write = wr_en && dp_idx_reg == `RDSL_IDX_LEN_MODE;

    // Pin A follows its selected signal one cycle later.
    property p_pin_a_route;
        @(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> debug_pin_a_o == $past(pin_a_expect);
    endproperty
    a_pin_a_route: assert property (p_pin_a_route)
        else $error("pin A does not follow its selected signal");

    // Pin C honours its polarity bit.
    property p_pin_c_invert;
        @(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> debug_pin_c_o == $past(pin_c_expect);
    endproperty
    a_pin_c_invert: assert property (p_pin_c_invert)
        else $error("pin C polarity wrong");

    // A write to the pin B register sets the drive boost from bit 7.
    property p_boost;
        @(posedge core_clk_i) disable iff (reset_i)
        pin_b_write |=> port_drive_boost_o == $past(hwdata_i[7]);
    endproperty
    a_boost: assert property (p_boost)
        else $error("drive boost does not follow bit 7 of pin B");

    // Sync word high byte comes out of reset at its default.
    property p_sync_high_reset;
        @(posedge core_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> sync_word_o[15:8] == 8'hD3;
    endproperty
    a_sync_high_reset: assert property (p_sync_high_reset)
        else $error("sync high byte reset value wrong");

    // Sync word low byte comes out of reset at its default.
    property p_sync_low_reset;
        @(posedge core_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> sync_word_o[7:0] == 8'h91 && pkt_len_reg == 8'hFF;
    endproperty
    a_sync_low_reset: assert property (p_sync_low_reset)
        else $error("sync low byte or length reset value wrong");

    // A fixed-length packet ends with the limit as its length.
    property p_fixed_len;
        @(posedge core_clk_i) disable iff (reset_i)
        pkt_end_o && len_mode_reg == RDSL_LEN_FIXED && $stable(pkt_len_reg)
        |-> pkt_length_o == pkt_len_reg;
    endproperty
    a_fixed_len: assert property (p_fixed_len)
        else $error("fixed packet length differs from limit");

    // An over-length error is raised only for a length byte above limit.
    property p_var_error;
        @(posedge core_clk_i) disable iff (reset_i)
        pkt_error_o |-> $past(pkt_byte_i) > $past(pkt_len_reg)
                        && $past(len_mode_reg) == RDSL_LEN_VARIABLE
                        ##1 len_error_reg;
    endproperty
    a_var_error: assert property (p_var_error)
        else $error("over-length error without cause or not latched");

    // A mode write lands in the mode output one cycle later.
    property p_mode_write;
        @(posedge core_clk_i) disable iff (reset_i)
        mode_write |=> length_mode_o == $past(hwdata_i[1:0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("length mode write lost");

    // Bits 31:10, and bit 7 of pin A, read zero; a read wait state ends after one cycle.
    property p_unused_zero;
        @(posedge core_clk_i) disable iff (reset_i)
        dp_read_reg |=> hreadyout_o && hrdata_o[31:10] == 22'h0 &&
            (dp_idx_reg != `RDSL_IDX_PIN_A || hrdata_o[7] == 1'b0);
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits non-zero or read stalled");

endmodule
